//--- cicv_control_views.sv
// banked cpu interface control register with axi4-lite slave and pe line drive
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module cicv_control_views #(
	parameter logic EOI_READS_ONE = 1'b0,
	parameter logic FIQ_SELECT_READS_ONE = 1'b0,
	parameter logic LEGACY_SUPPORT = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [cicv_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [cicv_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [cicv_pkg::STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [cicv_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [cicv_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic security_disable,
	input wire cicv_pkg::cicv_sysreg_type sysreg,
	input wire logic group0_request,
	input wire logic group1_request,
	input wire logic bypass_irq,
	input wire logic bypass_fiq,
	output logic irq_to_pe,
	output logic fiq_to_pe,
	output cicv_pkg::cicv_ctrl_type control,
	output logic [cicv_pkg::BP_W-1:0] group0_split_point,
	output logic [cicv_pkg::BP_W-1:0] group1_split_point
);
	typedef struct packed {
		cicv_pkg::cicv_ctrl_type ctrl;
		logic aw_held;
		logic [cicv_pkg::ADDR_W-1:0] aw_addr;
		logic aw_nonsecure;
		logic w_held;
		logic [cicv_pkg::DATA_W-1:0] wdata;
		logic [cicv_pkg::STRB_W-1:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [cicv_pkg::DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic irq_out;
		logic fiq_out;
		cicv_pkg::cicv_ctrl_type eff;
		logic [cicv_pkg::BP_W-1:0] g0_point;
		logic [cicv_pkg::BP_W-1:0] g1_point;
	} cicv_state_type;

	cicv_state_type st;
	cicv_state_type next_st;
	logic [cicv_pkg::BP_W-1:0] point_secure;
	logic [cicv_pkg::BP_W-1:0] point_nonsecure;
	logic bank_write_secure;
	logic bank_write_nonsecure;
	logic [cicv_pkg::BP_W-1:0] bank_write_value;

	// merge one field of a write under the byte enables
	function automatic logic wbit(input logic old, input logic [31:0] d, input logic [31:0] m,
			input int pos);
		return m[pos] ? d[pos] : old;
	endfunction

	// secure point plus one, held at the top code
	function automatic logic [cicv_pkg::BP_W-1:0] point_plus_one(
			input logic [cicv_pkg::BP_W-1:0] p);
		logic [cicv_pkg::BP_W:0] sum;
		sum = {1'b0, p} + {{cicv_pkg::BP_W{1'b0}}, 1'b1};
		return sum[cicv_pkg::BP_W] ? cicv_pkg::BP_MAX : sum[cicv_pkg::BP_W-1:0];
	endfunction

	function automatic cicv_pkg::cicv_view_type pick_view(input logic ds, input logic ns);
		if (ds) begin
			return cicv_pkg::cicv_view_single;
		end
		return ns ? cicv_pkg::cicv_view_nonsecure : cicv_pkg::cicv_view_secure;
	endfunction

	cicv_point_bank u_point_bank (
		.aclk(aclk),
		.aresetn(aresetn),
		.write_secure(bank_write_secure),
		.write_nonsecure(bank_write_nonsecure),
		.write_value(bank_write_value),
		.point_secure(point_secure),
		.point_nonsecure(point_nonsecure)
	);

	// bus handshakes, register writes and reads, and pe line drive
	always_comb begin
		logic irq_lock;
		logic fiq_lock;
		logic [cicv_pkg::DATA_W-1:0] mask;
		logic [cicv_pkg::DATA_W-1:0] rd;
		logic rd_ok;
		logic wr_ok;
		logic irq_sig_on;
		logic fiq_sig_on;
		logic irq_block;
		logic fiq_block;
		cicv_pkg::cicv_view_type wview;
		cicv_pkg::cicv_view_type rview;
		cicv_pkg::cicv_ctrl_type c;
		cicv_pkg::cicv_ctrl_type e;
		irq_lock = 1'b0;
		fiq_lock = 1'b0;
		mask = '0;
		rd = '0;
		rd_ok = 1'b0;
		wr_ok = 1'b0;
		irq_sig_on = 1'b0;
		fiq_sig_on = 1'b0;
		irq_block = 1'b0;
		fiq_block = 1'b0;
		wview = cicv_pkg::cicv_view_secure;
		rview = cicv_pkg::cicv_view_secure;
		next_st = st;
		bank_write_secure = 1'b0;
		bank_write_nonsecure = 1'b0;
		bank_write_value = st.wdata[cicv_pkg::BP_W-1:0];
		c = st.ctrl;

		// highest level sysreg control locks the bypass bits
		// no legacy support locks them too
		irq_lock = (sysreg.el3_enable & sysreg.sysreg_irq_bypass_block) | ~LEGACY_SUPPORT;
		fiq_lock = (sysreg.el3_enable & sysreg.sysreg_fiq_bypass_block) | ~LEGACY_SUPPORT;

		// effective values: stored bit or forced one
		e = c;
		// split mode bits may read as one
		e.eoi_split_mode_nonsecure = c.eoi_split_mode_nonsecure | EOI_READS_ONE;
		e.eoi_split_mode_secure = c.eoi_split_mode_secure | EOI_READS_ONE;
		e.irq_bypass_block_group1 = c.irq_bypass_block_group1 | irq_lock;
		e.irq_bypass_block_group0 = c.irq_bypass_block_group0 | irq_lock;
		e.fiq_bypass_block_group1 = c.fiq_bypass_block_group1 | fiq_lock;
		e.fiq_bypass_block_group0 = c.fiq_bypass_block_group0 | fiq_lock;
		// fiq select may read as one
		e.group0_fast_line_select = c.group0_fast_line_select | FIQ_SELECT_READS_ONE;

		// write address and data are taken independently, in either order
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
			next_st.aw_nonsecure = s_axi_awprot[cicv_pkg::PROT_NS_POS];
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_held = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		// perform a write once both halves are held
		if (st.aw_held && st.w_held && !st.bvalid) begin
			for (int i = 0; i < cicv_pkg::STRB_W; i++) begin
				mask[8*i +: 8] = {8{st.wstrb[i]}};
			end
			wview = pick_view(security_disable, st.aw_nonsecure);
			wr_ok = 1'b1;
			if (st.aw_addr == cicv_pkg::ADDR_CONTROL) begin
				case (wview)
					// non-secure bits land in the shared flip-flops
					cicv_pkg::cicv_view_nonsecure: begin
						c.eoi_split_mode_nonsecure = wbit(c.eoi_split_mode_nonsecure,
							st.wdata, mask, cicv_pkg::NS_EOI_POS);
						c.irq_bypass_block_group1 = wbit(c.irq_bypass_block_group1,
							st.wdata, mask, cicv_pkg::NS_IRQ_G1_POS);
						c.fiq_bypass_block_group1 = wbit(c.fiq_bypass_block_group1,
							st.wdata, mask, cicv_pkg::NS_FIQ_G1_POS);
						c.group1_signal_enable = wbit(c.group1_signal_enable,
							st.wdata, mask, cicv_pkg::NS_EN_G1_POS);
					end
					cicv_pkg::cicv_view_secure,
					cicv_pkg::cicv_view_single: begin
						// non-secure split mode only in the secure view
						if (wview == cicv_pkg::cicv_view_secure) begin
							c.eoi_split_mode_nonsecure = wbit(c.eoi_split_mode_nonsecure,
								st.wdata, mask, cicv_pkg::S_EOI_NS_POS);
						end
						// secure and single split mode share one bit
						c.eoi_split_mode_secure = wbit(c.eoi_split_mode_secure,
							st.wdata, mask, cicv_pkg::S_EOI_S_POS);
						c.irq_bypass_block_group1 = wbit(c.irq_bypass_block_group1,
							st.wdata, mask, cicv_pkg::S_IRQ_G1_POS);
						c.fiq_bypass_block_group1 = wbit(c.fiq_bypass_block_group1,
							st.wdata, mask, cicv_pkg::S_FIQ_G1_POS);
						c.irq_bypass_block_group0 = wbit(c.irq_bypass_block_group0,
							st.wdata, mask, cicv_pkg::S_IRQ_G0_POS);
						c.fiq_bypass_block_group0 = wbit(c.fiq_bypass_block_group0,
							st.wdata, mask, cicv_pkg::S_FIQ_G0_POS);
						c.common_binary_point = wbit(c.common_binary_point,
							st.wdata, mask, cicv_pkg::S_COMMON_BINARY_POINT_POS);
						c.group0_fast_line_select = wbit(c.group0_fast_line_select,
							st.wdata, mask, cicv_pkg::S_FIQ_SEL_POS);
						c.group1_signal_enable = wbit(c.group1_signal_enable,
							st.wdata, mask, cicv_pkg::S_EN_G1_POS);
						c.group0_signal_enable = wbit(c.group0_signal_enable,
							st.wdata, mask, cicv_pkg::S_EN_G0_POS);
					end
					default: begin
						c = st.ctrl;
					end
				endcase
				// locked or read-one fields keep their stored value
				if (EOI_READS_ONE) begin
					c.eoi_split_mode_nonsecure = st.ctrl.eoi_split_mode_nonsecure;
					c.eoi_split_mode_secure = st.ctrl.eoi_split_mode_secure;
				end
				// writes to locked bypass bits are ignored
				if (irq_lock) begin
					c.irq_bypass_block_group1 = st.ctrl.irq_bypass_block_group1;
					c.irq_bypass_block_group0 = st.ctrl.irq_bypass_block_group0;
				end
				if (fiq_lock) begin
					c.fiq_bypass_block_group1 = st.ctrl.fiq_bypass_block_group1;
					c.fiq_bypass_block_group0 = st.ctrl.fiq_bypass_block_group0;
				end
				if (FIQ_SELECT_READS_ONE) begin
					c.group0_fast_line_select = st.ctrl.group0_fast_line_select;
				end
				next_st.ctrl = c;
			end else if (st.aw_addr == cicv_pkg::ADDR_SPLIT_POINT) begin
				if (wview == cicv_pkg::cicv_view_nonsecure) begin
					// non-secure writes ignored under common point
					bank_write_nonsecure = st.wstrb[0] & ~st.ctrl.common_binary_point;
				end else begin
					bank_write_secure = st.wstrb[0];
				end
			end else if (st.aw_addr == cicv_pkg::ADDR_ALIAS_SPLIT_POINT) begin
				// non-secure alias access is read-zero, write-ignored
				bank_write_nonsecure = st.wstrb[0] & (wview != cicv_pkg::cicv_view_nonsecure);
			end else begin
				wr_ok = 1'b0;
			end
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = wr_ok ? cicv_pkg::RESP_OKAY : cicv_pkg::RESP_SLVERR;
		end

		// read: data taken from the registers in the cycle the address is taken
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st.arready) begin
			rview = pick_view(security_disable, s_axi_arprot[cicv_pkg::PROT_NS_POS]);
			rd_ok = 1'b1;
			// reserved bits stay zero from the clear above
			if (s_axi_araddr == cicv_pkg::ADDR_CONTROL) begin
				case (rview)
					cicv_pkg::cicv_view_nonsecure: begin
						rd[cicv_pkg::NS_EOI_POS] = e.eoi_split_mode_nonsecure;
						rd[cicv_pkg::NS_IRQ_G1_POS] = e.irq_bypass_block_group1;
						rd[cicv_pkg::NS_FIQ_G1_POS] = e.fiq_bypass_block_group1;
						rd[cicv_pkg::NS_EN_G1_POS] = e.group1_signal_enable;
					end
					cicv_pkg::cicv_view_secure,
					cicv_pkg::cicv_view_single: begin
						// single view has one split mode at bit 9
						if (rview == cicv_pkg::cicv_view_secure) begin
							rd[cicv_pkg::S_EOI_NS_POS] = e.eoi_split_mode_nonsecure;
						end
						rd[cicv_pkg::S_EOI_S_POS] = e.eoi_split_mode_secure;
						rd[cicv_pkg::S_IRQ_G1_POS] = e.irq_bypass_block_group1;
						rd[cicv_pkg::S_FIQ_G1_POS] = e.fiq_bypass_block_group1;
						rd[cicv_pkg::S_IRQ_G0_POS] = e.irq_bypass_block_group0;
						rd[cicv_pkg::S_FIQ_G0_POS] = e.fiq_bypass_block_group0;
						rd[cicv_pkg::S_COMMON_BINARY_POINT_POS] = e.common_binary_point;
						rd[cicv_pkg::S_FIQ_SEL_POS] = e.group0_fast_line_select;
						rd[cicv_pkg::S_EN_G1_POS] = e.group1_signal_enable;
						rd[cicv_pkg::S_EN_G0_POS] = e.group0_signal_enable;
					end
					default: begin
						rd = '0;
					end
				endcase
			end else if (s_axi_araddr == cicv_pkg::ADDR_SPLIT_POINT) begin
				if (rview == cicv_pkg::cicv_view_nonsecure) begin
					// non-secure read gives secure point plus one under common point, else the non-secure copy
					rd[cicv_pkg::BP_W-1:0] = st.ctrl.common_binary_point ?
						point_plus_one(point_secure) : point_nonsecure;
				end else begin
					rd[cicv_pkg::BP_W-1:0] = point_secure;
				end
			end else if (s_axi_araddr == cicv_pkg::ADDR_ALIAS_SPLIT_POINT) begin
				if (rview != cicv_pkg::cicv_view_nonsecure) begin
					rd[cicv_pkg::BP_W-1:0] = point_nonsecure;
				end
			end else begin
				rd_ok = 1'b0;
			end
			next_st.rvalid = 1'b1;
			next_st.rdata = rd;
			next_st.rresp = rd_ok ? cicv_pkg::RESP_OKAY : cicv_pkg::RESP_SLVERR;
		end

		// ready outputs are registered; they follow the next held state
		next_st.awready = ~next_st.aw_held & ~next_st.bvalid;
		next_st.wready = ~next_st.w_held & ~next_st.bvalid;
		next_st.arready = ~next_st.rvalid;

		// group 1 only ever uses irq
		irq_sig_on = e.group1_signal_enable |
			(e.group0_signal_enable & ~e.group0_fast_line_select);
		fiq_sig_on = e.group0_signal_enable & e.group0_fast_line_select;
		// os level sysreg access makes these bits ignored
		irq_block = ~sysreg.el1_enable &
			(e.irq_bypass_block_group0 | e.irq_bypass_block_group1);
		fiq_block = ~sysreg.el1_enable &
			(e.fiq_bypass_block_group0 | e.fiq_bypass_block_group1);
		// bypass irq passes only while irq signalling is off and unblocked
		if (irq_sig_on) begin
			// group 1 gated by its enable
			next_st.irq_out = (group1_request & e.group1_signal_enable) |
				(group0_request & e.group0_signal_enable & ~e.group0_fast_line_select);
		end else begin
			next_st.irq_out = bypass_irq & ~irq_block;
		end
		// bypass fiq passes only while fiq signalling is off and unblocked
		if (fiq_sig_on) begin
			// group 0 gated by its enable
			next_st.fiq_out = group0_request;
		end else begin
			next_st.fiq_out = bypass_fiq & ~fiq_block;
		end
		next_st.eff = e;
		// common point makes the secure point govern both groups
		next_st.g0_point = point_secure;
		next_st.g1_point = e.common_binary_point ? point_secure : point_nonsecure;
	end

	// all control fields clear at reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.ctrl <= cicv_pkg::CTRL_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign irq_to_pe = st.irq_out;
	assign fiq_to_pe = st.fiq_out;
	assign control = st.eff;
	assign group0_split_point = st.g0_point;
	assign group1_split_point = st.g1_point;
endmodule

//--- cicv_control_views_assertions.sv
// concurrent checks on the top ports of the control views block
`timescale 1ns/1ns
module cicv_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire cicv_pkg::cicv_sysreg_type sysreg,
	input wire logic group0_request,
	input wire logic group1_request,
	input wire logic bypass_irq,
	input wire logic bypass_fiq,
	input wire logic irq_to_pe,
	input wire logic fiq_to_pe,
	input wire cicv_pkg::cicv_ctrl_type control,
	input wire logic [cicv_pkg::BP_W-1:0] group0_split_point,
	input wire logic [cicv_pkg::BP_W-1:0] group1_split_point
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// lines lag inputs by one edge and are built from the same state as control
	wire irq_on = control.group1_signal_enable
		| (control.group0_signal_enable & ~control.group0_fast_line_select);
	wire fiq_on = control.group0_signal_enable & control.group0_fast_line_select;
	wire irq_blk = control.irq_bypass_block_group0 | control.irq_bypass_block_group1;
	wire fiq_blk = control.fiq_bypass_block_group0 | control.fiq_bypass_block_group1;
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_r_answer;
		s_axi_rvalid && !s_axi_arready;
	endsequence
	property p_r_after_ar;
		s_ar_taken |=> s_r_answer;
	endproperty
	a_r_after_ar: assert property (p_r_after_ar) else $error("read answer late");
	property p_b_once;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_once: assert property (p_b_once) else $error("write answer repeated");
	property p_irq_on;
		irq_on && $past(aresetn) |-> irq_to_pe == (($past(group1_request)
			& control.group1_signal_enable) | ($past(group0_request)
			& control.group0_signal_enable & ~control.group0_fast_line_select));
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq line wrong");
	property p_irq_off;
		!irq_on && $past(aresetn) |->
			irq_to_pe == ($past(bypass_irq) & ~(irq_blk & ~$past(sysreg.el1_enable)));
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq bypass wrong");
	property p_fiq_on;
		fiq_on && $past(aresetn) |-> fiq_to_pe == $past(group0_request);
	endproperty
	a_fiq_on: assert property (p_fiq_on) else $error("fiq line wrong");
	property p_fiq_off;
		!fiq_on && $past(aresetn) |->
			fiq_to_pe == ($past(bypass_fiq) & ~(fiq_blk & ~$past(sysreg.el1_enable)));
	endproperty
	a_fiq_off: assert property (p_fiq_off) else $error("fiq bypass wrong");
	property p_reset;
		$past(!aresetn) |-> control == '0 && group1_split_point == '0 && !irq_to_pe;
	endproperty
	a_reset: assert property (p_reset) else $error("reset value wrong");
	property p_lock;
		$past(sysreg.el3_enable & sysreg.sysreg_irq_bypass_block) && $past(aresetn)
			|-> control.irq_bypass_block_group0 && control.irq_bypass_block_group1;
	endproperty
	a_lock: assert property (p_lock) else $error("irq block not forced");
	property p_common_binary_point;
		control.common_binary_point |-> group1_split_point == group0_split_point;
	endproperty
	a_common_binary_point: assert property (p_common_binary_point) else $error("common point not shared");
endmodule

//--- cicv_pe_model.sv
// processing element stand-in that samples the two interrupt lines
`timescale 1ns/1ns
module cicv_pe_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic irq_line,
	input wire logic fiq_line,
	output logic irq_seen,
	output logic fiq_seen
);
	// plain levels with no handshake, so the core just samples them each cycle
	always_ff @(posedge aclk) begin
		irq_seen <= aresetn & irq_line;
		fiq_seen <= aresetn & fiq_line;
	end
endmodule

//--- cicv_pkg.sv
// shared constants, field layouts and carrier types of the cpu interface control views
// What this block does
// - non-secure view bit 9 sets non-secure end-of-interrupt split mode.
// - secure view holds non-secure split mode at bit 10, secure at bit 9.
// - with security disabled one split mode bit at 9 governs every access.
// - secure split mode and single-state split mode are one flip-flop.
// - any split mode bit may be built as read-one, writes ignored.
// - with irq signalling off, irq bypass block bits gate the bypass irq line.
// - with fiq signalling off, fiq bypass block bits gate the bypass fiq line.
// - highest level sysreg access with its block control set forces bits to one.
// - os level sysreg access makes this register's bypass block bits ignored.
// - without legacy support every bypass block bit may read one, writes ignored.
// - bit 4 picks common or separate binary point for the two groups.
// - common point with two states: non-secure read gives secure point plus one.
// - bit 3 sends group 0 on fiq instead of irq; group 1 always irq.
// - with two security states the fiq select bit may read one, writes ignored.
// - group 1 enable at bit 0 non-secure, bit 1 secure, gates group 1.
// - secure bit 0 enables signalling of group 0 interrupts.
// - every writable control field resets to zero.
// - security enabled gives separate secure and non-secure views, else one view.
// - reserved bits in every view read as zero.
package cicv_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;
	localparam int STRB_W = DATA_W / 8;
	localparam int BP_W = 3;
	// register byte offsets
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_SPLIT_POINT = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_ALIAS_SPLIT_POINT = 12'h01C;
	// non-secure view field positions
	localparam int NS_EOI_POS = 9;
	localparam int NS_IRQ_G1_POS = 6;
	localparam int NS_FIQ_G1_POS = 5;
	localparam int NS_EN_G1_POS = 0;
	// secure view field positions, single view shares them below bit 10
	localparam int S_EOI_NS_POS = 10;
	localparam int S_EOI_S_POS = 9;
	localparam int S_IRQ_G1_POS = 8;
	localparam int S_FIQ_G1_POS = 7;
	localparam int S_IRQ_G0_POS = 6;
	localparam int S_FIQ_G0_POS = 5;
	localparam int S_COMMON_BINARY_POINT_POS = 4;
	localparam int S_FIQ_SEL_POS = 3;
	localparam int S_EN_G1_POS = 1;
	localparam int S_EN_G0_POS = 0;
	localparam int SINGLE_EOI_POS = 9;
	localparam logic [BP_W-1:0] BP_MAX = 3'h7;
	localparam logic [BP_W-1:0] BP_RESET = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// prot bit 1 set marks a non-secure access
	localparam int PROT_NS_POS = 1;

	typedef enum logic [1:0] {
		cicv_view_nonsecure,
		cicv_view_secure,
		cicv_view_single
	} cicv_view_type;

	typedef struct packed {
		logic eoi_split_mode_nonsecure;
		logic eoi_split_mode_secure;
		logic irq_bypass_block_group1;
		logic fiq_bypass_block_group1;
		logic irq_bypass_block_group0;
		logic fiq_bypass_block_group0;
		logic common_binary_point;
		logic group0_fast_line_select;
		logic group1_signal_enable;
		logic group0_signal_enable;
	} cicv_ctrl_type;

	localparam cicv_ctrl_type CTRL_RESET = '0;

	typedef struct packed {
		logic el3_enable;
		logic el1_enable;
		logic sysreg_irq_bypass_block;
		logic sysreg_fiq_bypass_block;
	} cicv_sysreg_type;

	typedef struct packed {
		logic [BP_W-1:0] secure;
		logic [BP_W-1:0] nonsecure;
	} cicv_bank_type;
endpackage

//--- cicv_point_bank.sv
// banked binary point storage, one copy per security state
`timescale 1ns/1ns
module cicv_point_bank (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic write_secure,
	input wire logic write_nonsecure,
	input wire logic [cicv_pkg::BP_W-1:0] write_value,
	output logic [cicv_pkg::BP_W-1:0] point_secure,
	output logic [cicv_pkg::BP_W-1:0] point_nonsecure
);
	cicv_pkg::cicv_bank_type st;
	cicv_pkg::cicv_bank_type next_st;

	// each copy loads only on its own strobe
	always_comb begin
		next_st = st;
		if (write_secure) begin
			next_st.secure = write_value;
		end
		if (write_nonsecure) begin
			next_st.nonsecure = write_value;
		end
	end

	// reset value is a plain constant; the field has no defined reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st.secure <= cicv_pkg::BP_RESET;
			st.nonsecure <= cicv_pkg::BP_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign point_secure = st.secure;
	assign point_nonsecure = st.nonsecure;
endmodule

//--- test_cpu_iface_control_views.sv
// self-checking bench for the banked control views over axi4-lite
`timescale 1ns/1ns
module test_cpu_iface_control_views;
	localparam logic [11:0] CA = cicv_pkg::ADDR_CONTROL;
	localparam logic [11:0] SP = cicv_pkg::ADDR_SPLIT_POINT;
	localparam logic [11:0] AL = cicv_pkg::ADDR_ALIAS_SPLIT_POINT;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, cs = '0, d;
	logic [3:0] s_axi_wstrb = 4'hF, sv;
	logic [1:0] s_axi_bresp, s_axi_rresp, e1 = '0, e2 = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1;
	logic s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, irq_to_pe, fiq_to_pe, irq_seen, fiq_seen;
	logic security_disable = 0, group0_request = 0, group1_request = 0;
	logic bypass_irq = 0, bypass_fiq = 0, chk = 0, rnd = 0;
	cicv_pkg::cicv_sysreg_type sysreg = '0;
	cicv_pkg::cicv_ctrl_type control;
	logic [2:0] group0_split_point, group1_split_point;
	int n_mismatch = 0, tests_run = 0, seed = 32'h52662EA7, k;
	logic [33:0] r_q[$];
	logic [1:0] b_q[$];
	// line cases: sysreg nibble over a secure control value
	logic [15:0] lc [9] = '{16'h0000, 16'h0040, 16'h4040, 16'h0080, 16'h0009,
		16'h0003, 16'hA000, 16'h0021, 16'h9001};
	wire [2:0] rdy = {s_axi_bvalid, s_axi_rvalid, s_axi_arready};
	cicv_control_views dut (.*);
	cicv_pe_model pe (.aclk, .aresetn, .irq_line(irq_to_pe), .fiq_line(fiq_to_pe),
		.irq_seen, .fiq_seen);
	initial begin
		forever #4 aclk = ~aclk;
	end
	task automatic wrap_up();
		$display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic hang();
		n_mismatch++;
		wrap_up();
	endtask
	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// wait for a slave answer, ending on the handshake edge
	task automatic wt(input int w);
		int i;
		@(negedge aclk);
		for (i = 0; i < 40 && !rdy[w]; i++)
			@(negedge aclk);
		if (i == 40)
			hang();
		@(posedge aclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic ns, input logic [31:0] v);
		int i;
		logic pa, pw;
		// only the three mapped offsets answer okay
		b_q.push_back((a == CA || a == SP || a == AL) ? cicv_pkg::RESP_OKAY :
			cicv_pkg::RESP_SLVERR);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awprot <= {1'h0, ns, 1'h0};
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		pa = 1'h1;
		pw = 1'h1;
		// each channel is released on its own handshake edge
		for (i = 0; pa | pw; i++) begin
			if (i == 40)
				hang();
			@(negedge aclk);
			pa = pa & ~s_axi_awready;
			pw = pw & ~s_axi_wready;
			@(posedge aclk);
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		wt(2);
	endtask
	task automatic rd(input logic [11:0] a, input logic ns, input logic [33:0] e);
		r_q.push_back(e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arprot <= {1'h0, ns, 1'h0};
		s_axi_arvalid <= 1'h1;
		wt(0);
		s_axi_arvalid <= 1'h0;
		wt(1);
	endtask
	function automatic logic [31:0] to_ns(input logic [31:0] s);
		return {22'h0, s[10], 2'h0, s[8], s[7], 4'h0, s[1]};
	endfunction
	function automatic logic [31:0] from_ns(input logic [31:0] s, input logic [31:0] v);
		return (s & ~32'h582) | {21'h0, v[9], 1'h0, v[6], v[5], 5'h0, v[0], 1'h0};
	endfunction
	// expected line levels from the bench copy of control and the inputs now
	function automatic logic [1:0] lines(input logic [31:0] c, input logic [3:0] s);
		logic ib, fb;
		ib = (c[8] | c[6] | (s[3] & s[1])) & ~s[2];
		fb = (c[7] | c[5] | (s[3] & s[0])) & ~s[2];
		lines[1] = (c[1] | (c[0] & ~c[3])) ?
			((group1_request & c[1]) | (group0_request & c[0] & ~c[3])) : bypass_irq & ~ib;
		lines[0] = (c[0] & c[3]) ? group0_request : bypass_fiq & ~fb;
	endfunction
	// random request and bypass levels while line cases run
	always @(posedge aclk) begin
		if (rnd)
			{group0_request, group1_request, bypass_irq, bypass_fiq} <= 4'($random(seed));
	end
	// answers are taken oldest note first; the pe copy lags two cycles
	always @(negedge aclk) begin
		if (s_axi_rvalid && s_axi_rready)
			check({s_axi_rresp, s_axi_rdata}, r_q.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			check(34'(s_axi_bresp), 34'(b_q.pop_front()));
		if (chk)
			check(34'({irq_seen, fiq_seen}), 34'(e2));
		if (chk)
			check(34'(control), 34'({cs[10:3], cs[1:0]}));
		e2 = e1;
		e1 = lines(cs, sysreg);
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		rd(CA, 0, 34'h0);
		rd(SP, 0, 34'h0);
		rd(12'h004, 0, {cicv_pkg::RESP_SLVERR, 32'h0});
		// an unmapped write must not reach the control bits
		wr(12'h004, 0, 32'h7FB);
		rd(CA, 0, 34'h0);
		$display("test reset done");
		for (k = 0; k < 6; k++) begin
			d = $random(seed);
			wr(CA, 0, d);
			cs = d & 32'h7FB;
			rd(CA, 0, {2'h0, cs});
			rd(CA, 1, {2'h0, to_ns(cs)});
			d = $random(seed);
			wr(CA, 1, d);
			cs = from_ns(cs, d);
			rd(CA, 0, {2'h0, cs});
		end
		$display("test banked views done");
		security_disable <= 1'h1;
		d = $random(seed);
		wr(CA, 1, d);
		rd(CA, 0, {2'h0, d & 32'h3FB});
		cs = (cs & 32'h400) | (d & 32'h3FB);
		security_disable <= 1'h0;
		rd(CA, 0, {2'h0, cs});
		$display("test single view done");
		wr(CA, 0, 32'h10);
		cs = 32'h10;
		for (k = 3; k < 8; k += 4) begin
			wr(SP, 0, 32'(k));
			wr(SP, 1, 32'h1);
			rd(SP, 0, 34'(k));
			rd(SP, 1, 34'((k == 7) ? 7 : k + 1));
			@(negedge aclk);
			check(34'({group0_split_point, group1_split_point}), 34'({k[2:0], k[2:0]}));
		end
		// alias copy: secure side writes it, non-secure side sees zero
		wr(AL, 0, 32'h5);
		rd(AL, 0, 34'h5);
		rd(AL, 1, 34'h0);
		wr(CA, 0, 32'h0);
		rd(SP, 1, 34'h5);
		@(negedge aclk);
		check(34'({group0_split_point, group1_split_point}), 34'h3D);
		$display("test split point done");
		rnd <= 1'h1;
		foreach (lc[j]) begin
			sv = lc[j][15:12];
			sysreg <= sv;
			cs = {20'h0, lc[j][11:0]};
			wr(CA, 0, cs);
			cs = cs | {23'h0, sv[3] & sv[1], sv[3] & sv[0], sv[3] & sv[1], sv[3] & sv[0], 5'h0};
			rd(CA, 0, {2'h0, cs});
			repeat (3) @(posedge aclk);
			chk <= 1'h1;
			repeat (12) @(posedge aclk);
			chk <= 1'h0;
		end
		$display("test lines done");
		wrap_up();
	end
endmodule
bind cicv_control_views cicv_checker chk_i (.*);
